/* File: include/scoreboard_pkg.sv */
// constants, field layouts and carrier structs of the unit and register reservation scoreboard
// Summary of operation
// - no issue while the target unit still holds an uncompleted instruction
// - no issue while the result register is reserved by an uncompleted instruction
// - both conflicts are decided combinationally within the issue cycle
// - issue proceeds on a pending source; the unit waits for that result
// - a finished result stays in its unit while an earlier reader still needs the register
// - units request release shortly before their result; grant only when the path is clear
// - a grant clears the unit's reservations and wakes every waiting operand
// - a unit waiting on operands never blocks later independent issue
// - per unit: operation code, result, first and second source designators
// - per source operand: number of the unit that will produce it
// - per source operand: one ready flag
// - unit numbers follow the fixed octal code table; code 10 is unused
// - multiply and increment each have two separate units
// - issue marks busy, loads codes, copies producers, then reserves the result register
// - a unit starts only when both operand ready flags are set
// - a zero producer number sets the ready flag right after issue
package scoreboard_pkg;
   localparam int NUM_UNITS = 16;
   localparam int UID_W     = 4;
   localparam int REG_W     = 5;
   localparam int NUM_REGS  = 24;
   localparam int OPC_W     = 6;
   localparam int AXI_AW    = 8;
   // ==============================================
   // unit numbers
   localparam logic [UID_W-1:0] UNIT_BRANCH   = 4'h0;
   localparam logic [UID_W-1:0] UNIT_INCR1    = 4'h1;
   localparam logic [UID_W-1:0] UNIT_INCR2    = 4'h2;
   localparam logic [UID_W-1:0] UNIT_SHIFT    = 4'h3;
   localparam logic [UID_W-1:0] UNIT_BOOLEAN  = 4'h4;
   localparam logic [UID_W-1:0] UNIT_DIVIDE   = 4'h5;
   localparam logic [UID_W-1:0] UNIT_MULT1    = 4'h6;
   localparam logic [UID_W-1:0] UNIT_MULT2    = 4'h7;
   localparam logic [UID_W-1:0] UNIT_UNUSED   = 4'h8;
   localparam logic [UID_W-1:0] UNIT_RDCH1    = 4'h9;
   localparam logic [UID_W-1:0] UNIT_RDCH5    = 4'hd;
   localparam logic [UID_W-1:0] UNIT_FIXADD   = 4'he;
   localparam logic [UID_W-1:0] UNIT_FLTADD   = 4'hf;
   localparam logic [UID_W-1:0] UNIT_NONE     = 4'h0;
   // ==============================================
   // register numbering: operand, index, address groups
   localparam logic [REG_W-1:0] REG_X_BASE = 5'h00;
   localparam logic [REG_W-1:0] REG_B_BASE = 5'h08;
   localparam logic [REG_W-1:0] REG_A_BASE = 5'h10;
   // ==============================================
   // register bus map
   localparam logic [AXI_AW-1:0] OFS_CTRL    = 8'h00;
   localparam logic [AXI_AW-1:0] OFS_BUSY    = 8'h04;
   localparam logic [AXI_AW-1:0] OFS_WAITING = 8'h08;
   localparam logic [AXI_AW-1:0] OFS_STARTED = 8'h0c;
   localparam int               CTRL_ISSUE_EN_BIT = 0;
   localparam logic             CTRL_ISSUE_EN_RST = 1'b1;
   localparam logic [1:0]       RESP_OKAY   = 2'h0;
   localparam logic [1:0]       RESP_SLVERR = 2'h2;
   // ==============================================
   // carriers
   typedef struct packed {
      logic [OPC_W-1:0] opc;
      logic [UID_W-1:0] unit;
      logic             fi_en;
      logic [REG_W-1:0] fi;
      logic             fj_en;
      logic [REG_W-1:0] fj;
      logic             fk_en;
      logic [REG_W-1:0] fk;
   } issue_req_t;
   typedef struct packed {
      logic [OPC_W-1:0] unit_operation_code;
      logic             fi_en;
      logic [REG_W-1:0] result_reg_designator;
      logic [REG_W-1:0] first_source_designator;
      logic [REG_W-1:0] second_source_designator;
   } unit_cmd_t;
   typedef struct packed {
      logic             busy;
      logic             started;
      unit_cmd_t        cmd;
      logic             fj_en;
      logic             fk_en;
      logic [UID_W-1:0] first_source_producer_id;
      logic [UID_W-1:0] second_source_producer_id;
      logic             rj;
      logic             rk;
   } unit_state_t;
   typedef struct packed {
      logic [AXI_AW-1:0] awaddr;
      logic              awvalid;
      logic [31:0]       wdata;
      logic [3:0]        wstrb;
      logic              wvalid;
      logic              bready;
      logic [AXI_AW-1:0] araddr;
      logic              arvalid;
      logic              rready;
   } axil_req_t;
   typedef struct packed {
      logic        awready;
      logic        wready;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        arready;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
   } axil_rsp_t;
endpackage

/* File: core/unit_register_reservation_scoreboard.sv */
// unit and register reservation scoreboard with its register bus slave
`timescale 1ns/1ps
module unit_register_reservation_scoreboard (
   input  wire logic                              mclk_in,
   input  wire logic                              srst_in,
   input  wire scoreboard_pkg::axil_req_t         axi_in,
   output      scoreboard_pkg::axil_rsp_t         axi_out,
   input  wire logic                              issue_valid_in,
   input  wire scoreboard_pkg::issue_req_t        issue_in,
   output      logic                              issue_ready_out,
   output      logic [scoreboard_pkg::NUM_UNITS-1:0] start_out,
   input  wire logic [scoreboard_pkg::NUM_UNITS-1:0] release_req_in,
   output      logic [scoreboard_pkg::NUM_UNITS-1:0] grant_out,
   output      scoreboard_pkg::unit_cmd_t [scoreboard_pkg::NUM_UNITS-1:0] unit_cmd_out
);
   localparam int NU = scoreboard_pkg::NUM_UNITS;
   localparam int NR = scoreboard_pkg::NUM_REGS;
   localparam int UW = scoreboard_pkg::UID_W;
   localparam int RW = scoreboard_pkg::REG_W;

   // ==============================================
   // state
   typedef struct packed {
      scoreboard_pkg::unit_state_t [NU-1:0] units;
      // owner ids: x group, then index group, then address group
      logic [NR-1:0][UW-1:0] reg_owner;
      logic                  issue_en;
      logic                  aw_h;
      logic [scoreboard_pkg::AXI_AW-1:0] aw_a;
      logic                  w_h;
      logic [31:0]           w_d;
      logic [3:0]            w_s;
      logic                  bvalid;
      logic [1:0]            bresp;
      logic                  rvalid;
      logic [31:0]           rdata;
      logic [1:0]            rresp;
   } state_t;

   state_t s_r;
   state_t s_nxt;

   logic [NU-1:0] grant_v;
   logic [NU-1:0] start_v;
   logic [NR-1:0] pend_v;
   logic          ready_v;
   logic [NU-1:0] busy_v;
   logic [NU-1:0] started_v;

   // owner of a register; out-of-range numbers read as no producer
   function automatic logic [UW-1:0] owner_of(input logic [NR-1:0][UW-1:0] tbl,
                                             input logic [RW-1:0] r);
      logic [UW-1:0] o;
      o = scoreboard_pkg::UNIT_NONE;
      if (32'(r) < NR) begin
         o = tbl[r];
      end
      return o;
   endfunction

   function automatic logic [31:0] reg_read(input state_t s,
                                           input logic [scoreboard_pkg::AXI_AW-1:0] a,
                                           input logic [NU-1:0] bz,
                                           input logic [NU-1:0] st);
      logic [31:0] d;
      d = 32'h0000_0000;
      case (a)
         scoreboard_pkg::OFS_CTRL:    d[scoreboard_pkg::CTRL_ISSUE_EN_BIT] = s.issue_en;
         scoreboard_pkg::OFS_BUSY:    d[NU-1:0] = bz;
         scoreboard_pkg::OFS_WAITING: d[NU-1:0] = bz & ~st;
         scoreboard_pkg::OFS_STARTED: d[NU-1:0] = st;
         default:                     d = 32'h0000_0000;
      endcase
      return d;
   endfunction

   function automatic logic addr_ok(input logic [scoreboard_pkg::AXI_AW-1:0] a);
      return (a == scoreboard_pkg::OFS_CTRL) || (a == scoreboard_pkg::OFS_BUSY) ||
             (a == scoreboard_pkg::OFS_WAITING) || (a == scoreboard_pkg::OFS_STARTED);
   endfunction

   // ==============================================
   // next state
   always_comb begin
      logic [UW-1:0] iu;
      logic [UW-1:0] qj;
      logic [UW-1:0] qk;
      logic          unit_busy;
      logic          reg_reserved;
      logic          bad_target;
      logic          aw_now;
      logic          w_now;
      iu = issue_in.unit;
      qj = scoreboard_pkg::UNIT_NONE;
      qk = scoreboard_pkg::UNIT_NONE;
      unit_busy = 1'b0;
      reg_reserved = 1'b0;
      bad_target = 1'b0;
      aw_now = 1'b0;
      w_now = 1'b0;
      s_nxt = s_r;
      pend_v = '0;
      grant_v = '0;
      start_v = '0;

      // registers with a set read flag in an unstarted unit are not all clear
      for (int u = 0; u < NU; u++) begin
         busy_v[u] = s_r.units[u].busy;
         started_v[u] = s_r.units[u].started;
         if (s_r.units[u].busy && !s_r.units[u].started) begin
            if (s_r.units[u].fj_en && s_r.units[u].rj &&
                32'(s_r.units[u].cmd.first_source_designator) < NR) begin
               pend_v[s_r.units[u].cmd.first_source_designator] = 1'b1;
            end
            if (s_r.units[u].fk_en && s_r.units[u].rk &&
                32'(s_r.units[u].cmd.second_source_designator) < NR) begin
               pend_v[s_r.units[u].cmd.second_source_designator] = 1'b1;
            end
         end
      end

      for (int u = 0; u < NU; u++) begin
         // start waits on both flags; grant waits for the destination to be all clear
         start_v[u] = s_r.units[u].busy && !s_r.units[u].started &&
                      s_r.units[u].rj && s_r.units[u].rk;
         grant_v[u] = release_req_in[u] && s_r.units[u].busy && s_r.units[u].started &&
                      !(s_r.units[u].cmd.fi_en &&
                        pend_v[s_r.units[u].cmd.result_reg_designator]);
      end

      for (int u = 0; u < NU; u++) begin
         if (start_v[u]) begin
            s_nxt.units[u].started = 1'b1;
            s_nxt.units[u].rj = 1'b0;
            s_nxt.units[u].rk = 1'b0;
         end
         if (grant_v[u]) begin
            s_nxt.units[u].busy = 1'b0;
            s_nxt.units[u].started = 1'b0;
         end
         // release of the producer sets the flag of every waiting operand
         if (s_r.units[u].busy && !s_r.units[u].started) begin
            if (!s_r.units[u].rj && grant_v[s_r.units[u].first_source_producer_id]) begin
               s_nxt.units[u].rj = 1'b1;
               s_nxt.units[u].first_source_producer_id = scoreboard_pkg::UNIT_NONE;
            end
            if (!s_r.units[u].rk && grant_v[s_r.units[u].second_source_producer_id]) begin
               s_nxt.units[u].rk = 1'b1;
               s_nxt.units[u].second_source_producer_id = scoreboard_pkg::UNIT_NONE;
            end
         end
      end

      for (int r = 0; r < NR; r++) begin
         if (s_r.reg_owner[r] != scoreboard_pkg::UNIT_NONE &&
             grant_v[s_r.reg_owner[r]]) begin
            s_nxt.reg_owner[r] = scoreboard_pkg::UNIT_NONE;
         end
      end

      // conflicts use present state only, so the decision settles in the issue cycle
      unit_busy = s_r.units[iu].busy;
      reg_reserved = issue_in.fi_en &&
                     owner_of(s_r.reg_owner, issue_in.fi) != scoreboard_pkg::UNIT_NONE;
      // code 10 has no unit; the branch unit may not reserve a result
      bad_target = (iu == scoreboard_pkg::UNIT_UNUSED) ||
                   (issue_in.fi_en && (iu == scoreboard_pkg::UNIT_BRANCH ||
                                       32'(issue_in.fi) >= NR));
      // waiting units do not enter this decision, so later work keeps issuing
      ready_v = s_r.issue_en && !unit_busy && !reg_reserved && !bad_target;

      if (issue_valid_in && ready_v) begin
         if (issue_in.fj_en) begin
            qj = owner_of(s_r.reg_owner, issue_in.fj);
         end
         if (issue_in.fk_en) begin
            qk = owner_of(s_r.reg_owner, issue_in.fk);
         end
         s_nxt.units[iu].busy = 1'b1;
         s_nxt.units[iu].started = 1'b0;
         s_nxt.units[iu].cmd.unit_operation_code = issue_in.opc;
         s_nxt.units[iu].cmd.fi_en = issue_in.fi_en;
         s_nxt.units[iu].cmd.result_reg_designator = issue_in.fi;
         s_nxt.units[iu].cmd.first_source_designator = issue_in.fj;
         s_nxt.units[iu].cmd.second_source_designator = issue_in.fk;
         s_nxt.units[iu].fj_en = issue_in.fj_en;
         s_nxt.units[iu].fk_en = issue_in.fk_en;
         // a producer released in this very cycle counts as already done
         if (qj == scoreboard_pkg::UNIT_NONE || grant_v[qj]) begin
            s_nxt.units[iu].rj = 1'b1;
            s_nxt.units[iu].first_source_producer_id = scoreboard_pkg::UNIT_NONE;
         end else begin
            s_nxt.units[iu].rj = 1'b0;
            s_nxt.units[iu].first_source_producer_id = qj;
         end
         if (qk == scoreboard_pkg::UNIT_NONE || grant_v[qk]) begin
            s_nxt.units[iu].rk = 1'b1;
            s_nxt.units[iu].second_source_producer_id = scoreboard_pkg::UNIT_NONE;
         end else begin
            s_nxt.units[iu].rk = 1'b0;
            s_nxt.units[iu].second_source_producer_id = qk;
         end
         if (issue_in.fi_en) begin
            s_nxt.reg_owner[issue_in.fi] = iu;
         end
      end

      // ==============================================
      // register bus: address and data taken in either order
      aw_now = axi_in.awvalid && !s_r.aw_h && !s_r.bvalid;
      w_now = axi_in.wvalid && !s_r.w_h && !s_r.bvalid;
      if (aw_now) begin
         s_nxt.aw_h = 1'b1;
         s_nxt.aw_a = axi_in.awaddr;
      end
      if (w_now) begin
         s_nxt.w_h = 1'b1;
         s_nxt.w_d = axi_in.wdata;
         s_nxt.w_s = axi_in.wstrb;
      end
      if (s_r.aw_h && s_r.w_h && !s_r.bvalid) begin
         s_nxt.aw_h = 1'b0;
         s_nxt.w_h = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = addr_ok(s_r.aw_a) ? scoreboard_pkg::RESP_OKAY
                                         : scoreboard_pkg::RESP_SLVERR;
         if (s_r.aw_a == scoreboard_pkg::OFS_CTRL && s_r.w_s[0]) begin
            s_nxt.issue_en = s_r.w_d[scoreboard_pkg::CTRL_ISSUE_EN_BIT];
         end
      end
      if (s_r.bvalid && axi_in.bready) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.rvalid && axi_in.rready) begin
         s_nxt.rvalid = 1'b0;
      end
      if (axi_in.arvalid && !s_r.rvalid) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rdata = reg_read(s_r, axi_in.araddr, busy_v, started_v);
         s_nxt.rresp = addr_ok(axi_in.araddr) ? scoreboard_pkg::RESP_OKAY
                                              : scoreboard_pkg::RESP_SLVERR;
      end
   end

   // ==============================================
   // registers
   always_ff @(posedge mclk_in) begin
      if (srst_in) begin
         s_r <= '0;
         s_r.issue_en <= scoreboard_pkg::CTRL_ISSUE_EN_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ==============================================
   // outputs
   assign issue_ready_out = ready_v;
   assign start_out = start_v;
   assign grant_out = grant_v;

   genvar g;
   generate
      for (g = 0; g < NU; g++) begin : g_cmd
         assign unit_cmd_out[g] = s_r.units[g].cmd;
      end
   endgenerate

   assign axi_out.awready = !s_r.aw_h && !s_r.bvalid;
   assign axi_out.wready = !s_r.w_h && !s_r.bvalid;
   assign axi_out.bvalid = s_r.bvalid;
   assign axi_out.bresp = s_r.bresp;
   assign axi_out.arready = !s_r.rvalid;
   assign axi_out.rvalid = s_r.rvalid;
   assign axi_out.rdata = s_r.rdata;
   assign axi_out.rresp = s_r.rresp;

endmodule // unit_register_reservation_scoreboard

/* File: tb/sb_checker.sv */
// assertions on the scoreboard's issue, start and release ports
`timescale 1ns/1ps
module sb_checker (
   input wire logic                                          mclk_in,
   input wire logic                                          srst_in,
   input wire scoreboard_pkg::axil_req_t                     axi_in,
   input wire scoreboard_pkg::axil_rsp_t                     axi_out,
   input wire logic                                          issue_valid_in,
   input wire scoreboard_pkg::issue_req_t                    issue_in,
   input wire logic                                          issue_ready_out,
   input wire logic [15:0]                                   start_out,
   input wire logic [15:0]                                   release_req_in,
   input wire logic [15:0]                                   grant_out,
   input wire scoreboard_pkg::unit_cmd_t [15:0]              unit_cmd_out
);
   default clocking cb @(posedge mclk_in); endclocking
   default disable iff (srst_in);
   logic fire;
   assign fire = issue_valid_in && issue_ready_out;
   // ==========================================
   // issue conflicts and command load
   property p_unit_busy;
      fire ##1 (issue_valid_in && issue_in.unit == $past(issue_in.unit)) |-> !issue_ready_out;
   endproperty
   a_unit_busy: assert property (p_unit_busy) else $error("issue to busy unit");
   property p_reg_owned;
      fire && issue_in.fi_en ##1 (issue_valid_in && issue_in.fi_en
         && issue_in.fi == $past(issue_in.fi)) |-> !issue_ready_out;
   endproperty
   a_reg_owned: assert property (p_reg_owned) else $error("issue to owned register");
   property p_unused;
      issue_valid_in && issue_in.unit == scoreboard_pkg::UNIT_UNUSED |-> !issue_ready_out;
   endproperty
   a_unused: assert property (p_unused) else $error("issue to unused code");
   property p_cmd_load;
      fire && issue_in.fi_en |=> unit_cmd_out[$past(issue_in.unit)].result_reg_designator
         == $past(issue_in.fi);
   endproperty
   a_cmd_load: assert property (p_cmd_load) else $error("designator not loaded");
   // ==========================================
   // start and release
   property p_free_start;
      fire && !issue_in.fj_en && !issue_in.fk_en |=> start_out[$past(issue_in.unit)];
   endproperty
   a_free_start: assert property (p_free_start) else $error("free unit did not start");
   property p_start_pulse;
      start_out != 16'h0 |=> (start_out & $past(start_out)) == 16'h0;
   endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start held");
   property p_grant_req;
      (grant_out & ~release_req_in) == 16'h0;
   endproperty
   a_grant_req: assert property (p_grant_req) else $error("grant without request");
   property p_grant_once;
      (grant_out & release_req_in) != 16'h0 |=> (grant_out & $past(grant_out)) == 16'h0;
   endproperty
   a_grant_once: assert property (p_grant_once) else $error("grant repeated");
endmodule // sb_checker

/* File: tb/unit_model.sv */
// behavioural functional units: start, run, then request release
`timescale 1ns/1ps
module unit_model (
   input  wire logic        mclk_in,
   input  wire logic        srst_in,
   input  wire logic [15:0] start_in,
   input  wire logic [15:0] grant_in,
   input  wire logic [15:0] hold_in,
   output      logic [15:0] req_out
);
   logic [15:0] run_r;
   logic [1:0]  cnt_r [16];
   // hold_in stands for a slow unit that delays its request
   always_ff @(posedge mclk_in) begin
      for (int u = 0; u < 16; u++) begin
         if (srst_in) begin
            run_r[u] <= 1'b0;
            req_out[u] <= 1'b0;
            cnt_r[u] <= 2'h0;
         end else if (start_in[u]) begin
            run_r[u] <= 1'b1;
            cnt_r[u] <= 2'h2;
         end else if (req_out[u] && grant_in[u]) begin
            run_r[u] <= 1'b0;
            req_out[u] <= 1'b0;
         end else if (run_r[u] && cnt_r[u] != 2'h0) begin
            cnt_r[u] <= cnt_r[u] - 2'h1;
         end else if (run_r[u] && !hold_in[u]) begin
            req_out[u] <= 1'b1;
         end
      end
   end
endmodule // unit_model

/* File: tb/testbench.sv */
// self-checking bench for the reservation scoreboard
`timescale 1ns/1ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin err_count++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, a); end end
module testbench;
   localparam logic [3:0] FA = scoreboard_pkg::UNIT_FLTADD;
   localparam logic [3:0] DV = scoreboard_pkg::UNIT_DIVIDE;
   localparam logic [3:0] XA = scoreboard_pkg::UNIT_FIXADD;
   localparam logic [3:0] M1 = scoreboard_pkg::UNIT_MULT1;
   localparam logic [3:0] M2 = scoreboard_pkg::UNIT_MULT2;
   localparam logic [1:0] OK = scoreboard_pkg::RESP_OKAY;
   localparam logic [1:0] SE = scoreboard_pkg::RESP_SLVERR;
   logic                            mclk_in = 1'b0;
   logic                            srst_in = 1'b1;
   logic                            issue_valid_in = 1'b0;
   logic                            issue_ready_out;
   scoreboard_pkg::axil_req_t       axi_in = '0;
   scoreboard_pkg::axil_rsp_t       axi_out;
   scoreboard_pkg::issue_req_t      issue_in = '0;
   logic [15:0]                     start_out, release_req_in, grant_out;
   logic [15:0]                     hold = 16'h0;
   scoreboard_pkg::unit_cmd_t [15:0] unit_cmd_out;
   int                              err_count = 0, checks = 0, cyc = 0, n;
   int                              start_cnt [16] = '{default: 0};
   int                              gnt_cnt [16] = '{default: 0};
   logic [1:0]                      rs;
   unit_register_reservation_scoreboard u_unit_register_reservation_scoreboard (.mclk_in,
      .srst_in, .axi_in, .axi_out, .issue_valid_in, .issue_in, .issue_ready_out, .start_out,
      .release_req_in, .grant_out, .unit_cmd_out);
   unit_model u_unit_model (.mclk_in, .srst_in, .start_in(start_out), .grant_in(grant_out),
      .hold_in(hold), .req_out(release_req_in));
   always #12.5 mclk_in = ~mclk_in;
   always @(posedge mclk_in) begin
      cyc++;
      for (int u = 0; u < 16; u++) begin
         if (start_out[u] === 1'b1) start_cnt[u]++;
         if ((grant_out[u] & release_req_in[u]) === 1'b1) gnt_cnt[u]++;
      end
      // the verdict ends the run, so the ceiling test stands last in this process
      if (cyc == 5000) begin
         err_count++;
         stop_test();
      end
   end
   // ==========================================
   // tasks
   task automatic stop_test();
      $display("checks %0d errors %0d", checks, err_count);
      if (err_count == 0 && checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic clk(input int k);
      repeat (k) @(posedge mclk_in);
   endtask
   // leaves valid high so back-to-back issues never assign it twice in a step
   task automatic issue(input logic [3:0] u, input logic [4:0] i, j, k, input logic e,
                        output int w);
      w = 0;
      issue_in <= '{opc: 6'h05, unit: u, fi_en: 1'b1, fi: i, fj_en: e, fj: j, fk_en: e, fk: k};
      issue_valid_in <= 1'b1;
      @(negedge mclk_in);
      while (issue_ready_out !== 1'b1 && w < 200) begin
         w++;
         @(negedge mclk_in);
      end
      @(posedge mclk_in);
   endtask
   task automatic off();
      issue_valid_in <= 1'b0;
      @(posedge mclk_in);
   endtask
   task automatic refuse(input logic [3:0] u, input logic [4:0] i);
      issue_in <= '{opc: 6'h05, unit: u, fi_en: 1'b1, fi: i, default: '0};
      issue_valid_in <= 1'b1;
      repeat (3) begin
         @(negedge mclk_in);
         `CHK("issue_ready", 1'b0, issue_ready_out)
      end
      @(posedge mclk_in);
      off();
   endtask
   task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      axi_in.awaddr <= a;
      axi_in.awvalid <= 1'b1;
      axi_in.wdata <= d;
      axi_in.wstrb <= 4'hf;
      axi_in.wvalid <= 1'b1;
      axi_in.bready <= 1'b1;
      do begin
         @(posedge mclk_in);
         if (axi_out.awready) axi_in.awvalid <= 1'b0;
         if (axi_out.wready) axi_in.wvalid <= 1'b0;
      end while (axi_out.bvalid !== 1'b1);
      r = axi_out.bresp;
      axi_in.bready <= 1'b0;
      @(posedge mclk_in);
   endtask
   task automatic rchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
      axi_in.araddr <= a;
      axi_in.arvalid <= 1'b1;
      axi_in.rready <= 1'b1;
      do begin
         @(posedge mclk_in);
         if (axi_out.arready) axi_in.arvalid <= 1'b0;
      end while (axi_out.rvalid !== 1'b1);
      `CHK("rdata", e, axi_out.rdata)
      `CHK("rresp", er, axi_out.rresp)
      axi_in.rready <= 1'b0;
      @(posedge mclk_in);
   endtask
   // ==========================================
   // main sequence
   initial begin
      clk(5);
      srst_in <= 1'b0;
      clk(1);
      rchk(scoreboard_pkg::OFS_CTRL, 32'h1, OK);
      rchk(8'h40, 32'h0, SE);
      axw(8'h40, 32'h1, rs);
      `CHK("bresp", SE, rs)
      axw(scoreboard_pkg::OFS_CTRL, 32'h0, rs);
      refuse(FA, 5'h06);
      axw(scoreboard_pkg::OFS_CTRL, 32'h1, rs);
      refuse(scoreboard_pkg::UNIT_UNUSED, 5'h01);
      refuse(scoreboard_pkg::UNIT_BRANCH, 5'h01);
      refuse(XA, 5'h18);
      hold[FA] <= 1'b1;
      issue(FA, 5'h06, 5'h01, 5'h02, 1'b1, n);
      issue(DV, 5'h07, 5'h05, 5'h06, 1'b1, n);
      `CHK("waits", 0, n)
      // same unit and same result register right behind an accepted issue
      refuse(DV, 5'h07);
      `CHK("fi", 5'h06, unit_cmd_out[FA].result_reg_designator)
      refuse(XA, 5'h06);
      refuse(FA, 5'h00);
      rchk(scoreboard_pkg::OFS_BUSY, 32'h8020, OK);
      rchk(scoreboard_pkg::OFS_WAITING, 32'h0020, OK);
      rchk(scoreboard_pkg::OFS_STARTED, 32'h8000, OK);
      `CHK("dv_start", 0, start_cnt[DV])
      hold <= 16'h0;
      clk(12);
      `CHK("fa_grant", 1, gnt_cnt[FA])
      `CHK("dv_start", 1, start_cnt[DV])
      `CHK("dv_grant", 1, gnt_cnt[DV])
      issue(XA, 5'h06, 5'h00, 5'h00, 1'b0, n);
      `CHK("waits", 0, n)
      issue(M1, 5'h01, 5'h03, 5'h04, 1'b0, n);
      issue(M2, 5'h02, 5'h03, 5'h04, 1'b0, n);
      `CHK("waits", 0, n)
      off();
      clk(10);
      `CHK("m2_start", 1, start_cnt[M2])
      rchk(scoreboard_pkg::OFS_BUSY, 32'h0, OK);
      hold[DV] <= 1'b1;
      issue(DV, 5'h03, 5'h01, 5'h02, 1'b1, n);
      issue(M1, 5'h05, 5'h04, 5'h03, 1'b1, n);
      issue(FA, 5'h04, 5'h00, 5'h06, 1'b1, n);
      off();
      clk(10);
      `CHK("fa_req", 1'b1, release_req_in[FA])
      `CHK("fa_grant", 1, gnt_cnt[FA])
      hold <= 16'h0;
      clk(14);
      `CHK("m1_start", 2, start_cnt[M1])
      `CHK("fa_grant", 2, gnt_cnt[FA])
      stop_test();
   end
endmodule // testbench
bind unit_register_reservation_scoreboard sb_checker u_sb_checker (.mclk_in, .srst_in,
   .axi_in, .axi_out, .issue_valid_in, .issue_in, .issue_ready_out, .start_out,
   .release_req_in, .grant_out, .unit_cmd_out);
